/* logic/csvdec_cfg.svh */
// constants for the cyclic velocity control word decoder
`ifndef CSVDEC_CFG_SVH
`define CSVDEC_CFG_SVH
// ==========================================================
// register offsets
`define CSVDEC_OFS_CTRL    16'h6040
`define CSVDEC_OFS_VEL     16'h60ff
`define CSVDEC_OFS_COND    16'h7000
`define CSVDEC_OFS_STATUS  16'h7004
// ==========================================================
// control word fields
`define CSVDEC_BIT_HALT    8
`define CSVDEC_BIT_TYPE_LO 12
`define CSVDEC_BIT_TYPE_HI 13
`define CSVDEC_CTRL_RST    16'h0000
`define CSVDEC_CTRL_USED   16'h3100
// ==========================================================
// condition register bits
`define CSVDEC_COND_OPEN   0
`define CSVDEC_COND_EXCITE 1
`define CSVDEC_COND_STOP   2
`define CSVDEC_COND_LIMIT  3
`define CSVDEC_COND_RST    4'h0
// ==========================================================
// velocity limits and push deviation
`define CSVDEC_VEL_MAX     32'sd4000000
`define CSVDEC_VEL_MIN     (-32'sd4000000)
`define CSVDEC_VEL_RST     32'sh00000000
`define CSVDEC_PUSH_DEV_MDEG 16'd2700
`define CSVDEC_BACKOFF_MDEG  16'd3600
// ==========================================================
// status register bits
`define CSVDEC_ST_VEL_OK   12
`define CSVDEC_ST_HALTED   8
`endif

/* logic/csvdec_pkg.sv */
// types for the cyclic velocity control word decoder
package csvdec_pkg;
  typedef enum logic [1:0] {
    CSVDEC_RUN_POS,
    CSVDEC_RUN_SPD,
    CSVDEC_RUN_PUSH
  } csvdec_run_t;
  typedef enum {
    CSVDEC_ST_IDLE,
    CSVDEC_ST_MOVE,
    CSVDEC_ST_HOLD
  } csvdec_state_t;
endpackage

/* logic/csvdec_if.sv */
// decoded fields between word decoder and top
`timescale 1ns/1ps
interface csvdec_if;
  logic [15:0] word;
  logic        halt;
  logic [1:0]  type_code;
  logic        pos_mode;
  logic        spd_mode;
  logic        push_mode;
  modport dec (input word, output halt, type_code, pos_mode, spd_mode,
               push_mode);
  modport top (output word, input halt, type_code, pos_mode, spd_mode,
               push_mode);
endinterface // csvdec_if

/* logic/csvdec_word.sv */
// combinational decode of the control word fields
`timescale 1ns/1ps
`include "csvdec_cfg.svh"
module csvdec_word
  import csvdec_pkg::*;
(
  csvdec_if.dec port_if
);
  assign port_if.halt      = port_if.word[`CSVDEC_BIT_HALT];
  assign port_if.type_code = {port_if.word[`CSVDEC_BIT_TYPE_HI],
                              port_if.word[`CSVDEC_BIT_TYPE_LO]};
  assign port_if.pos_mode  = (port_if.type_code == 2'h0);
  assign port_if.spd_mode  = (port_if.type_code == 2'h1);
  // codes 10 and 11 behave alike here
  assign port_if.push_mode = port_if.type_code[1];
endmodule // csvdec_word

/* logic/csvdec_top.sv */
// cyclic velocity control word decoder top
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "csvdec_cfg.svh"
module csvdec_top
  import csvdec_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic [15:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_load_contact,
  input  wire logic        i_overload,
  input  wire logic        i_deviation,
  output logic      [31:0] o_rdata,
  output logic signed [31:0] o_vel_cmd,
  output logic      [1:0]  o_run_mode,
  output logic             o_run_en,
  output logic             o_quick_stop,
  output logic             o_push_hold,
  output logic      [15:0] o_hold_dev_mdeg,
  output logic             o_alarm_overload,
  output logic             o_alarm_deviation,
  output logic             o_vel_ok
);
  // ========================================================
  // registers
  logic        [15:0] ctrl_r;
  logic signed [31:0] vel_r;
  logic        [3:0]  cond_r;
  logic        [31:0] rdata_nxt;
  logic               vel_ok_nxt;
  logic               lim_active;
  csvdec_state_t      state_r;
  csvdec_if           dec_if ();

  assign dec_if.word = ctrl_r & `CSVDEC_CTRL_USED;

  csvdec_word u_word (
    .port_if (dec_if)
  );

  // ========================================================
  // register writes
  // only decoded bits stored
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl_r <= `CSVDEC_CTRL_RST;
    end else if (i_wr && i_addr == `CSVDEC_OFS_CTRL) begin
      ctrl_r <= i_wdata[15:0] & `CSVDEC_CTRL_USED;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      vel_r <= `CSVDEC_VEL_RST;
    end else if (i_wr && i_addr == `CSVDEC_OFS_VEL) begin
      if ($signed(i_wdata) > `CSVDEC_VEL_MAX) begin
        vel_r <= `CSVDEC_VEL_MAX;
      end else if ($signed(i_wdata) < `CSVDEC_VEL_MIN) begin
        vel_r <= `CSVDEC_VEL_MIN;
      end else begin
        vel_r <= $signed(i_wdata);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cond_r <= `CSVDEC_COND_RST;
    end else if (i_wr && i_addr == `CSVDEC_OFS_COND) begin
      cond_r <= i_wdata[3:0];
    end
  end

  // ========================================================
  // velocity acceptance
  assign lim_active = cond_r[`CSVDEC_COND_LIMIT];
  always_comb begin
    vel_ok_nxt = cond_r[`CSVDEC_COND_OPEN] &&
                 cond_r[`CSVDEC_COND_EXCITE] &&
                 !cond_r[`CSVDEC_COND_STOP] &&
                 !lim_active &&
                 !dec_if.halt;
  end

  // ========================================================
  // motion state
  // push holds once load is met
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_r <= CSVDEC_ST_IDLE;
    end else begin
      unique case (state_r)
        CSVDEC_ST_IDLE: begin
          if (vel_ok_nxt) begin
            state_r <= CSVDEC_ST_MOVE;
          end
        end
        CSVDEC_ST_MOVE: begin
          if (!vel_ok_nxt) begin
            state_r <= CSVDEC_ST_IDLE;
          end else if (dec_if.push_mode && i_load_contact) begin
            state_r <= CSVDEC_ST_HOLD;
          end
        end
        CSVDEC_ST_HOLD: begin
          if (!vel_ok_nxt) begin
            state_r <= CSVDEC_ST_IDLE;
          end else if (!dec_if.push_mode) begin
            state_r <= CSVDEC_ST_MOVE;
          end
        end
      endcase
    end
  end

  // ========================================================
  // outputs
  // mode follows field directly
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_run_mode <= CSVDEC_RUN_POS;
    end else if (dec_if.push_mode) begin
      o_run_mode <= CSVDEC_RUN_PUSH;
    end else if (dec_if.spd_mode) begin
      o_run_mode <= CSVDEC_RUN_SPD;
    end else begin
      o_run_mode <= CSVDEC_RUN_POS;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_quick_stop <= 1'b0;
      o_run_en     <= 1'b0;
      o_vel_cmd    <= `CSVDEC_VEL_RST;
      o_vel_ok     <= 1'b0;
    end else begin
      o_quick_stop <= dec_if.halt;
      o_run_en     <= vel_ok_nxt;
      o_vel_cmd    <= vel_ok_nxt ? vel_r : `CSVDEC_VEL_RST;
      o_vel_ok     <= vel_ok_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_push_hold     <= 1'b0;
      o_hold_dev_mdeg <= 16'h0000;
    end else begin
      o_push_hold     <= (state_r == CSVDEC_ST_HOLD);
      o_hold_dev_mdeg <= (state_r == CSVDEC_ST_HOLD) ?
                         `CSVDEC_PUSH_DEV_MDEG : 16'h0000;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_alarm_overload  <= 1'b0;
      o_alarm_deviation <= 1'b0;
    end else if (state_r == CSVDEC_ST_MOVE) begin
      // push never alarms while pressing; a stop pressed may still trip
      o_alarm_overload  <= o_alarm_overload |
                           (i_overload & !dec_if.push_mode);
      o_alarm_deviation <= o_alarm_deviation |
                           (i_deviation & dec_if.pos_mode);
    end
  end

  // ========================================================
  // read port, data one cycle after strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (i_addr)
      `CSVDEC_OFS_CTRL:   rdata_nxt = {16'h0000, ctrl_r};
      `CSVDEC_OFS_VEL:    rdata_nxt = vel_r;
      `CSVDEC_OFS_COND:   rdata_nxt = {28'h0000000, cond_r};
      `CSVDEC_OFS_STATUS: begin
        rdata_nxt[`CSVDEC_ST_VEL_OK] = vel_ok_nxt;
        rdata_nxt[`CSVDEC_ST_HALTED] = dec_if.halt;
        rdata_nxt[1:0]               = state_r == CSVDEC_ST_HOLD ? 2'h2 :
                                       state_r == CSVDEC_ST_MOVE ? 2'h1 :
                                       2'h0;
      end
      default:            rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ========================================================
  // checks
  a_halt_stops: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    ctrl_r[`CSVDEC_BIT_HALT] |=> o_quick_stop && !o_run_en)
    else $error("halt did not stop");
  a_push_code_merge: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    ctrl_r[`CSVDEC_BIT_TYPE_HI] |=> o_run_mode == CSVDEC_RUN_PUSH)
    else $error("push codes differ");
  a_mode_immediate: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    ctrl_r[13:12] == 2'h1 |=> o_run_mode == CSVDEC_RUN_SPD)
    else $error("mode change late");
  a_vel_range: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    vel_r <= `CSVDEC_VEL_MAX && vel_r >= `CSVDEC_VEL_MIN)
    else $error("velocity out of range");
  a_ignore_status: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    cond_r[`CSVDEC_COND_STOP] |=> !o_vel_ok && o_vel_cmd == 0)
    else $error("ignored command accepted");
  a_hold_dev: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    o_push_hold |-> o_hold_dev_mdeg == `CSVDEC_PUSH_DEV_MDEG)
    else $error("hold deviation wrong");
  a_spd_no_dev: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    !o_alarm_deviation && state_r == CSVDEC_ST_MOVE && dec_if.spd_mode
    |=> !o_alarm_deviation)
    else $error("speed mode raised deviation");
  a_pos_dev_alarm: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    state_r == CSVDEC_ST_MOVE && dec_if.pos_mode && i_deviation
    |=> o_alarm_deviation)
    else $error("deviation alarm missing");
  a_push_enter_hold: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    state_r == CSVDEC_ST_MOVE && vel_ok_nxt && dec_if.push_mode &&
    i_load_contact |=> ##1 o_push_hold)
    else $error("push hold missing");
  a_reserved_clear: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (ctrl_r & ~`CSVDEC_CTRL_USED) == 16'h0000)
    else $error("reserved bits stored");
endmodule // csvdec_top

/* dv/csvdec_master.sv */
// fieldbus master model driving the register port
`timescale 1ns/1ps
`include "csvdec_cfg.svh"
module csvdec_master (
  input  wire logic        i_core_clk,
  input  wire logic [31:0] i_rdata,
  output logic      [15:0] o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial begin
    o_addr  = 16'h0000;
    o_wdata = 32'h00000000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // ==========================================================
  // bus cycles
  // velocity goes out as one signed 32-bit word
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_core_clk);
    o_wr    <= 1'b0;
    // released write data flips so a stale value never passes
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_core_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
  // back off before ending push motion
  task automatic end_push();
    wr(`CSVDEC_OFS_VEL, -32'sd1000);
    wr(`CSVDEC_OFS_CTRL, 32'h00000000);
  endtask
endmodule // csvdec_master

/* dv/csvdec_top_tb.sv */
// self-checking bench for the control word decoder
`timescale 1ns/1ps
`include "csvdec_cfg.svh"
module csvdec_top_tb;
  logic        i_core_clk, i_reset, i_wr, i_rd;
  logic        i_load_contact, i_overload, i_deviation;
  logic [15:0] i_addr, hold;
  logic [31:0] i_wdata, o_rdata, d;
  logic signed [31:0] o_vel_cmd;
  logic [1:0]  o_run_mode;
  logic        o_run_en, o_quick_stop, o_push_hold, o_vel_ok;
  logic        o_alarm_overload, o_alarm_deviation;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [3:0]  blk_cond [4] = '{4'h2, 4'h1, 4'h7, 4'hb};
  always #4 i_core_clk = ~i_core_clk;
  csvdec_top uut (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_load_contact(i_load_contact), .i_overload(i_overload),
    .i_deviation(i_deviation), .o_rdata(o_rdata),
    .o_vel_cmd(o_vel_cmd), .o_run_mode(o_run_mode),
    .o_run_en(o_run_en), .o_quick_stop(o_quick_stop),
    .o_push_hold(o_push_hold), .o_hold_dev_mdeg(hold),
    .o_alarm_overload(o_alarm_overload),
    .o_alarm_deviation(o_alarm_deviation), .o_vel_ok(o_vel_ok));
  csvdec_master m (.i_core_clk(i_core_clk), .i_rdata(o_rdata),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w();
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask
  task automatic rst(input int n);
    i_reset        <= 1'b1;
    i_load_contact <= 1'b0;
    i_overload     <= 1'b0;
    i_deviation    <= 1'b0;
    repeat (n) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic run(input logic [31:0] ctrl);
    m.wr(`CSVDEC_OFS_COND, 32'h3);
    m.wr(`CSVDEC_OFS_VEL, 32'sd1000);
    m.wr(`CSVDEC_OFS_CTRL, ctrl);
    w();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    i_core_clk = 1'b0;
    rst(16);
    #1;
    chk(o_vel_cmd, 32'h0);
    m.rd(`CSVDEC_OFS_VEL, d);
    chk(d, 32'h0);
    run(32'h0);
    for (int i = 0; i < 4; i++) begin
      m.wr(`CSVDEC_OFS_CTRL, 32'(i) << 12);
      w();
      chk(o_run_mode, (i > 1) ? 32'h2 : 32'(i));
      chk(o_run_en, 32'h1);
    end
    chk(o_vel_cmd, 32'sd1000);
    $display("test modes done");
    m.wr(`CSVDEC_OFS_CTRL, 32'h0000cef7);
    w();
    chk(o_run_mode, 32'h0);
    chk(o_run_en, 32'h1);
    m.rd(`CSVDEC_OFS_CTRL, d);
    chk(d, 32'h0);
    m.rd(16'h1234, d);
    chk(d, 32'h0);
    $display("test reserved done");
    m.wr(`CSVDEC_OFS_CTRL, 32'h00000100);
    w();
    chk(o_quick_stop, 32'h1);
    chk(o_run_en, 32'h0);
    chk(o_vel_ok, 32'h0);
    m.rd(`CSVDEC_OFS_STATUS, d);
    chk(d[12], 32'h0);
    chk(d[8], 32'h1);
    m.wr(`CSVDEC_OFS_CTRL, 32'h0);
    // each condition word blocks the command
    foreach (blk_cond[k]) begin
      m.wr(`CSVDEC_OFS_COND, 32'(blk_cond[k]));
      w();
      chk(o_vel_ok, 32'h0);
      chk(o_vel_cmd, 32'h0);
    end
    m.wr(`CSVDEC_OFS_COND, 32'h3);
    w();
    chk(o_vel_ok, 32'h1);
    m.rd(`CSVDEC_OFS_STATUS, d);
    chk(d[12], 32'h1);
    $display("test halt done");
    m.wr(`CSVDEC_OFS_VEL, 32'sd5000000);
    w();
    chk(o_vel_cmd, `CSVDEC_VEL_MAX);
    m.wr(`CSVDEC_OFS_VEL, -32'sd5000000);
    w();
    chk(o_vel_cmd, `CSVDEC_VEL_MIN);
    $display("test limits done");
    run(32'h00001000);
    @(posedge i_core_clk);
    i_deviation <= 1'b1;
    w();
    chk(o_alarm_deviation, 32'h0);
    @(posedge i_core_clk);
    i_overload <= 1'b1;
    w();
    chk(o_alarm_overload, 32'h1);
    @(posedge i_core_clk);
    rst(2);
    run(32'h00002000);
    @(posedge i_core_clk);
    i_load_contact <= 1'b1;
    i_overload     <= 1'b1;
    w();
    chk(o_push_hold, 32'h1);
    chk(hold, 32'(`CSVDEC_PUSH_DEV_MDEG));
    chk(o_alarm_overload, 32'h0);
    m.rd(`CSVDEC_OFS_STATUS, d);
    chk(d[1:0], 32'h2);
    m.wr(`CSVDEC_OFS_CTRL, 32'h00003000);
    w();
    chk(o_push_hold, 32'h1);
    m.end_push();
    w();
    chk(o_push_hold, 32'h0);
    chk(hold, 32'h0);
    chk(o_alarm_overload, 32'h1);
    @(posedge i_core_clk);
    rst(2);
    run(32'h0);
    @(posedge i_core_clk);
    i_deviation <= 1'b1;
    w();
    chk(o_alarm_deviation, 32'h1);
    $display("test alarms done");
    test_done();
  end
  initial begin
    #20000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule // csvdec_top_tb
